// File: logic/rba_bank.sv
/*
 * rba_bank: one field of each bit-access attribute behind an apb slave,
 * with a hard-reset domain and a power-good (sticky) domain.
 * assumes: apb master keeps request stable until pready; req_src is
 * valid with the request; hardware event inputs are synchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module rba_bank (
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           pwr_good_n,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [rba_pkg::RBA_AW-1:0]     paddr,
	input  wire logic [rba_pkg::RBA_DW-1:0]     pwdata,
	input  wire logic [3:0]                     pstrb,
	input  wire logic [rba_pkg::RBA_SRC_W-1:0]  req_src,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_ro_data,
	input  wire logic                           hw_rw_we,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_rw_data,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_rc_set,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_rw1c_set,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_rw0c_set,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_readable_set_only_bit_clr,
	input  wire logic                           hw_ros_we,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_ros_data,
	input  wire logic [rba_pkg::RBA_FW-1:0]     hw_sticky_write_one_clear_bit_set,
	input  wire logic                           hw_lock,
	input  wire logic                           fw_wr_valid,
	input  wire logic [rba_pkg::RBA_FW-1:0]     fw_wr_data,
	output logic [rba_pkg::RBA_DW-1:0]          prdata,
	output logic                                pready,
	output logic                                pslverr,
	output rba_pkg::rba_ctl_t                   ctl,
	output rba_pkg::rba_stat_t                  stat,
	output rba_pkg::rba_sticky_t                sticky
);

	////////////////////////////////////////////////////////////////////////
	// state and reset combination

	rba_pkg::rba_hard_t   hq_r;
	rba_pkg::rba_hard_t   hq_nxt;
	rba_pkg::rba_sticky_t sq_r;
	rba_pkg::rba_sticky_t sq_nxt;
	logic                 rst_hard_n;
	logic                 acc;
	logic                 wr;
	logic                 rd;
	logic                 lock;
	logic                 bypass;
	logic [rba_pkg::RBA_FW-1:0] wd;

	// power-good reset also acts as a hard reset
	assign rst_hard_n = presetn & pwr_good_n;

	// access-phase decode; only byte lane 0 carries a field
	assign acc    = psel & penable & hq_r.ready;
	assign wr     = acc & pwrite & pstrb[0];
	assign rd     = acc & ~pwrite;
	assign wd     = pwdata[rba_pkg::RBA_FW-1:0];
	assign lock   = (|hq_r.c.kl) | hw_lock;
	assign bypass = hq_r.c.lb_en[req_src];

	////////////////////////////////////////////////////////////////////////
	// next state of the hard-reset fields and of the bus slave

	always_comb begin
		hq_nxt = hq_r;
		// one-cycle registered answer: ready in the access cycle
		hq_nxt.ready = psel & ~penable;
		if (psel & ~penable & ~pwrite) begin
			hq_nxt.rdata = rba_pkg::RBA_DEF_RDATA;
			unique case (paddr)
				rba_pkg::RBA_OFF_RO:    hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hw_ro_data;
				rba_pkg::RBA_OFF_RW:    hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.rw;
				rba_pkg::RBA_OFF_RC:    hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.s.rc;
				rba_pkg::RBA_OFF_RWO:   hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.rwo;
				rba_pkg::RBA_OFF_RWL:   hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.rwl;
				rba_pkg::RBA_OFF_KL:    hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.kl;
				rba_pkg::RBA_OFF_RW1C:  hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.s.rw1c;
				rba_pkg::RBA_OFF_RW0C:  hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.s.rw0c;
				rba_pkg::RBA_OFF_ROS:   hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = sq_r.sticky_readonly_bit;
				rba_pkg::RBA_OFF_READABLE_SET_ONLY_BIT:  hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.s.readable_set_only_bit;
				rba_pkg::RBA_OFF_RWS:   hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = sq_r.sticky_readwrite_bit;
				rba_pkg::RBA_OFF_STICKY_WRITE_ONE_CLEAR_BIT: hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = sq_r.sticky_write_one_clear_bit;
				rba_pkg::RBA_OFF_LB:    hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.lb;
				rba_pkg::RBA_OFF_LBEN:  hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.lb_en;
				rba_pkg::RBA_OFF_SLB:   hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = sq_r.slb;
				rba_pkg::RBA_OFF_FW:    hq_nxt.rdata[rba_pkg::RBA_FW-1:0] = hq_r.c.fw;
				default:                hq_nxt.rdata = rba_pkg::RBA_DEF_RDATA; // w1s, wo, unmapped
			endcase
		end

		// volatile read-write: hardware update wins over software
		if (hw_rw_we) begin
			hq_nxt.c.rw = hw_rw_data;
		end else if (wr && paddr == rba_pkg::RBA_OFF_RW) begin
			hq_nxt.c.rw = wd;
		end

		// clear only the bits returned by the read, new sets win
		hq_nxt.s.rc = hq_r.s.rc;
		if (rd && paddr == rba_pkg::RBA_OFF_RC) begin
			hq_nxt.s.rc = hq_r.s.rc & ~hq_r.rdata[rba_pkg::RBA_FW-1:0];
		end
		hq_nxt.s.rc = hq_nxt.s.rc | hw_rc_set;

		// write one to set, zeros ignored
		if (wr && paddr == rba_pkg::RBA_OFF_W1S) begin
			hq_nxt.c.w1s = hq_r.c.w1s | wd;
		end

		// write-only field takes microcode writes only
		if (wr && paddr == rba_pkg::RBA_OFF_WO && req_src == rba_pkg::RBA_SRC_UCODE) begin
			hq_nxt.c.wo = wd;
		end

		// first write after reset sticks, later ones ignored
		if (wr && paddr == rba_pkg::RBA_OFF_RWO && !hq_r.rwo_done) begin
			hq_nxt.c.rwo    = wd;
			hq_nxt.rwo_done = 1'b1;
		end

		// lockable field
		if (wr && paddr == rba_pkg::RBA_OFF_RWL && !lock) begin
			hq_nxt.c.rwl = wd;
		end

		// lock agent, itself locked by other logic
		if (wr && paddr == rba_pkg::RBA_OFF_KL && !hw_lock) begin
			hq_nxt.c.kl = wd;
		end

		// write one to clear, hardware set wins
		hq_nxt.s.rw1c = hq_r.s.rw1c | hw_rw1c_set;
		if (wr && paddr == rba_pkg::RBA_OFF_RW1C) begin
			hq_nxt.s.rw1c = (hq_r.s.rw1c & ~wd) | hw_rw1c_set;
		end

		// write zero to clear, hardware set wins
		hq_nxt.s.rw0c = hq_r.s.rw0c | hw_rw0c_set;
		if (wr && paddr == rba_pkg::RBA_OFF_RW0C) begin
			hq_nxt.s.rw0c = (hq_r.s.rw0c & wd) | hw_rw0c_set;
		end

		// readable set-only: only hardware clears, software set wins
		hq_nxt.s.readable_set_only_bit = hq_r.s.readable_set_only_bit & ~hw_readable_set_only_bit_clr;
		if (wr && paddr == rba_pkg::RBA_OFF_READABLE_SET_ONLY_BIT) begin
			hq_nxt.s.readable_set_only_bit = (hq_r.s.readable_set_only_bit & ~hw_readable_set_only_bit_clr) | wd;
		end

		// lock-bypass: enabled source groups write through the lock
		if (wr && paddr == rba_pkg::RBA_OFF_LB && (!lock || bypass)) begin
			hq_nxt.c.lb = wd;
		end

		// bypass enables are write-once
		if (wr && paddr == rba_pkg::RBA_OFF_LBEN && !hq_r.lben_done) begin
			hq_nxt.c.lb_en    = wd;
			hq_nxt.lben_done = 1'b1;
		end

		// forced-write field: bus writes ignored, side path only
		if (fw_wr_valid) begin
			hq_nxt.c.fw = fw_wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// next state of the sticky fields

	always_comb begin
		sq_nxt = sq_r;
		// sticky read-only, hardware only
		if (hw_ros_we) begin
			sq_nxt.sticky_readonly_bit = hw_ros_data;
		end
		// sticky read-write
		if (wr && paddr == rba_pkg::RBA_OFF_RWS) begin
			sq_nxt.sticky_readwrite_bit = wd;
		end
		// sticky write one to clear, hardware set wins
		sq_nxt.sticky_write_one_clear_bit = sq_r.sticky_write_one_clear_bit | hw_sticky_write_one_clear_bit_set;
		if (wr && paddr == rba_pkg::RBA_OFF_STICKY_WRITE_ONE_CLEAR_BIT) begin
			sq_nxt.sticky_write_one_clear_bit = (sq_r.sticky_write_one_clear_bit & ~wd) | hw_sticky_write_one_clear_bit_set;
		end
		// sticky lock-bypass
		if (wr && paddr == rba_pkg::RBA_OFF_SLB && (!lock || bypass)) begin
			sq_nxt.slb = wd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registers: hard domain and power-good domain

	// all non-sticky state returns to default on hard reset
	always_ff @(posedge pclk or negedge rst_hard_n) begin
		if (!rst_hard_n) begin
			hq_r.c.rw     <= rba_pkg::RBA_DEF_CTL;
			hq_r.c.w1s    <= rba_pkg::RBA_DEF_CTL;
			hq_r.c.wo     <= rba_pkg::RBA_DEF_CTL;
			hq_r.c.rwo    <= rba_pkg::RBA_DEF_CTL;
			hq_r.c.rwl    <= rba_pkg::RBA_DEF_CTL;
			hq_r.c.kl     <= rba_pkg::RBA_DEF_LOCK;
			hq_r.c.lb     <= rba_pkg::RBA_DEF_CTL;
			hq_r.c.lb_en  <= rba_pkg::RBA_DEF_LOCK;
			hq_r.c.fw     <= rba_pkg::RBA_DEF_CTL;
			hq_r.s.rc     <= rba_pkg::RBA_DEF_STAT;
			hq_r.s.rw1c   <= rba_pkg::RBA_DEF_STAT;
			hq_r.s.rw0c   <= rba_pkg::RBA_DEF_STAT;
			hq_r.s.readable_set_only_bit   <= rba_pkg::RBA_DEF_STAT;
			hq_r.rwo_done <= 1'b0;
			hq_r.lben_done <= 1'b0;
			hq_r.rdata    <= rba_pkg::RBA_DEF_RDATA;
			hq_r.ready    <= 1'b0;
		end else begin
			hq_r <= hq_nxt;
		end
	end

	// sticky state survives hard reset
	always_ff @(posedge pclk or negedge pwr_good_n) begin
		if (!pwr_good_n) begin
			sq_r.sticky_readonly_bit   <= rba_pkg::RBA_DEF_STICKY;
			sq_r.sticky_readwrite_bit   <= rba_pkg::RBA_DEF_STICKY;
			sq_r.sticky_write_one_clear_bit <= rba_pkg::RBA_DEF_STICKY;
			sq_r.slb   <= rba_pkg::RBA_DEF_STICKY;
		end else begin
			sq_r <= sq_nxt;
		end
	end

	// outputs straight from the state flops, except pslverr, which is tied low
	assign prdata  = hq_r.rdata;
	assign pready  = hq_r.ready;
	assign pslverr = 1'b0;   // unmapped reads zero, writes ignored
	assign ctl     = hq_r.c;
	assign stat    = hq_r.s;
	assign sticky  = sq_r;

	////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!rst_hard_n);

	a_ro_read_value: assert property (
		(psel && !penable && !pwrite && paddr == rba_pkg::RBA_OFF_RO)
		|=> prdata == {{(rba_pkg::RBA_DW-rba_pkg::RBA_FW){1'b0}}, $past(hw_ro_data)})
		else $error("read-only field read wrong value");

	a_rw_store_val: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RW && !hw_rw_we) |=> ctl.rw == $past(wd))
		else $error("read-write field did not store");

	a_rc_read_clr: assert property (
		(rd && paddr == rba_pkg::RBA_OFF_RC && hw_rc_set == '0)
		|=> (stat.rc & $past(prdata[rba_pkg::RBA_FW-1:0])) == '0)
		else $error("read-clear bits not cleared by read");

	a_w1s_sets: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_W1S) |=> (ctl.w1s & $past(wd)) == $past(wd)
		&& (ctl.w1s & $past(ctl.w1s)) == $past(ctl.w1s))
		else $error("write-one-set field wrong");

	a_wo_src_gate: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_WO && req_src != rba_pkg::RBA_SRC_UCODE)
		|=> $stable(ctl.wo))
		else $error("write-only field took non-microcode write");

	a_once_ignore: assert property (
		(hq_r.rwo_done && !hw_rw_we) |=> $stable(ctl.rwo) && hq_r.rwo_done)
		else $error("write-once field changed after first write");

	a_lock_hold: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RWL && (hw_lock || ctl.kl != '0))
		|=> $stable(ctl.rwl))
		else $error("locked field accepted a write");

	a_w1c_clear: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RW1C)
		|=> stat.rw1c == (($past(stat.rw1c) & ~$past(wd)) | $past(hw_rw1c_set)))
		else $error("write-one-clear result wrong");

	a_w0c_clear: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RW0C)
		|=> stat.rw0c == (($past(stat.rw0c) & $past(wd)) | $past(hw_rw0c_set)))
		else $error("write-zero-clear result wrong");

	a_readable_set_only_bit_hw_only: assert property (
		(hw_readable_set_only_bit_clr == '0) |=> (stat.readable_set_only_bit & $past(stat.readable_set_only_bit)) == $past(stat.readable_set_only_bit))
		else $error("set-only bit cleared without hardware");

	a_bypass_wr: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_LB && lock && bypass) |=> ctl.lb == $past(wd))
		else $error("bypass source write not applied");

	a_fw_core_ign: assert property (
		(!fw_wr_valid) |=> $stable(ctl.fw))
		else $error("forced-write field changed by bus");

	// acceptance and hold paths of the writable fields, and zero upper read data
	a_rwl_open_wr: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RWL && !lock) |=> ctl.rwl == $past(wd))
		else $error("unlocked field refused a write");

	a_kl_hw_hold: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_KL && hw_lock) |=> $stable(ctl.kl))
		else $error("lock agent written under external lock");

	a_kl_open_wr: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_KL && !hw_lock) |=> ctl.kl == $past(wd))
		else $error("lock agent refused a write");

	a_wo_ucode_wr: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_WO && req_src == rba_pkg::RBA_SRC_UCODE)
		|=> ctl.wo == $past(wd))
		else $error("write-only field lost a microcode write");

	a_once_first: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RWO && !hq_r.rwo_done)
		|=> ctl.rwo == $past(wd) && hq_r.rwo_done)
		else $error("write-once field lost its first write");

	a_lb_lock_hold: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_LB && lock && !bypass) |=> $stable(ctl.lb))
		else $error("locked bypass field took a write");

	a_lben_once: assert property (
		hq_r.lben_done |=> $stable(ctl.lb_en) && hq_r.lben_done)
		else $error("bypass enables changed after first write");

	a_fw_side_load: assert property (
		fw_wr_valid |=> ctl.fw == $past(fw_wr_data))
		else $error("forced-write side path not applied");

	a_rdata_upper: assert property (
		pready |-> prdata[rba_pkg::RBA_DW-1:rba_pkg::RBA_FW] == '0)
		else $error("read data above the field not zero");

	// sticky domain and pready pulse, checked under the hard reset that power-good also drives
	a_ros_bus_ign: assert property (
		!hw_ros_we |=> $stable(sticky.sticky_readonly_bit))
		else $error("sticky read-only field changed without hardware");

	a_rws_store: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_RWS) |=> sticky.sticky_readwrite_bit == $past(wd))
		else $error("sticky read-write field did not store");

	a_w1cs_clear: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_STICKY_WRITE_ONE_CLEAR_BIT)
		|=> sticky.sticky_write_one_clear_bit == (($past(sticky.sticky_write_one_clear_bit) & ~$past(wd)) | $past(hw_sticky_write_one_clear_bit_set)))
		else $error("sticky write-one-clear result wrong");

	a_slb_lock_hold: assert property (
		(wr && paddr == rba_pkg::RBA_OFF_SLB && lock && !bypass) |=> $stable(sticky.slb))
		else $error("locked sticky bypass field took a write");

	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("pready held over two cycles");

	c_rc_race: cover property (rd && paddr == rba_pkg::RBA_OFF_RC && hw_rc_set != '0);
	c_bypass_lock: cover property (wr && paddr == rba_pkg::RBA_OFF_LB && lock && bypass);
	c_once_second: cover property (wr && paddr == rba_pkg::RBA_OFF_RWO && hq_r.rwo_done);
	c_fw_write: cover property (fw_wr_valid ##[1:4] (rd && paddr == rba_pkg::RBA_OFF_FW));

endmodule // rba_bank

`default_nettype wire

// File: logic/rba_pkg.sv
/*
 * rba_pkg: constants, offsets, reset values and carrier types for the
 * register bit-attribute bank.
 * assumes: one 32-bit apb slave, one field of rba_fw bits per aligned word.
 */
`default_nettype none

package rba_pkg;

	localparam int RBA_FW    = 8;
	localparam int RBA_AW    = 8;
	localparam int RBA_DW    = 32;
	localparam int RBA_SRC_W = 2;

	// byte offsets of the field words
	localparam logic [RBA_AW-1:0] RBA_OFF_RO    = 8'h00;
	localparam logic [RBA_AW-1:0] RBA_OFF_RW    = 8'h04;
	localparam logic [RBA_AW-1:0] RBA_OFF_RC    = 8'h08;
	localparam logic [RBA_AW-1:0] RBA_OFF_W1S   = 8'h0c;
	localparam logic [RBA_AW-1:0] RBA_OFF_WO    = 8'h10;
	localparam logic [RBA_AW-1:0] RBA_OFF_RWO   = 8'h14;
	localparam logic [RBA_AW-1:0] RBA_OFF_RWL   = 8'h18;
	localparam logic [RBA_AW-1:0] RBA_OFF_KL    = 8'h1c;
	localparam logic [RBA_AW-1:0] RBA_OFF_RW1C  = 8'h20;
	localparam logic [RBA_AW-1:0] RBA_OFF_RW0C  = 8'h24;
	localparam logic [RBA_AW-1:0] RBA_OFF_ROS   = 8'h28;
	localparam logic [RBA_AW-1:0] RBA_OFF_READABLE_SET_ONLY_BIT  = 8'h2c;
	localparam logic [RBA_AW-1:0] RBA_OFF_RWS   = 8'h30;
	localparam logic [RBA_AW-1:0] RBA_OFF_STICKY_WRITE_ONE_CLEAR_BIT = 8'h34;
	localparam logic [RBA_AW-1:0] RBA_OFF_LB    = 8'h38;
	localparam logic [RBA_AW-1:0] RBA_OFF_LBEN  = 8'h3c;
	localparam logic [RBA_AW-1:0] RBA_OFF_SLB   = 8'h40;
	localparam logic [RBA_AW-1:0] RBA_OFF_FW    = 8'h44;

	// configuration request source groups
	localparam logic [RBA_SRC_W-1:0] RBA_SRC_LCORE = 2'h0;
	localparam logic [RBA_SRC_W-1:0] RBA_SRC_RCORE = 2'h1;
	localparam logic [RBA_SRC_W-1:0] RBA_SRC_UCODE = 2'h2;
	localparam logic [RBA_SRC_W-1:0] RBA_SRC_AGENT = 2'h3;

	// reset values
	localparam logic [RBA_FW-1:0] RBA_DEF_CTL    = 8'h00;
	localparam logic [RBA_FW-1:0] RBA_DEF_STAT   = 8'h00;
	localparam logic [RBA_FW-1:0] RBA_DEF_LOCK   = 8'h00;
	localparam logic [RBA_FW-1:0] RBA_DEF_STICKY = 8'h00;
	localparam logic [RBA_DW-1:0] RBA_DEF_RDATA  = 32'h0000_0000;

	// software-controlled field values, except fw, which only the side path writes
	typedef struct packed {
		logic [RBA_FW-1:0] rw;
		logic [RBA_FW-1:0] w1s;
		logic [RBA_FW-1:0] wo;
		logic [RBA_FW-1:0] rwo;
		logic [RBA_FW-1:0] rwl;
		logic [RBA_FW-1:0] kl;
		logic [RBA_FW-1:0] lb;
		logic [RBA_FW-1:0] lb_en;
		logic [RBA_FW-1:0] fw;
	} rba_ctl_t;

	// status fields, hardware-set except readable_set_only_bit, which hardware clears
	typedef struct packed {
		logic [RBA_FW-1:0] rc;
		logic [RBA_FW-1:0] rw1c;
		logic [RBA_FW-1:0] rw0c;
		logic [RBA_FW-1:0] readable_set_only_bit;
	} rba_stat_t;

	// state under the hard reset
	typedef struct packed {
		rba_ctl_t          c;
		rba_stat_t         s;
		logic              rwo_done;
		logic              lben_done;
		logic [RBA_DW-1:0] rdata;
		logic              ready;
	} rba_hard_t;

	// state under the power-good reset only
	typedef struct packed {
		logic [RBA_FW-1:0] sticky_readonly_bit;
		logic [RBA_FW-1:0] sticky_readwrite_bit;
		logic [RBA_FW-1:0] sticky_write_one_clear_bit;
		logic [RBA_FW-1:0] slb;
	} rba_sticky_t;

endpackage

`default_nettype wire

// File: tb/rba_bank_test.sv
/*
 * rba_bank_test: self-checking bench for the bit-attribute bank.
 * assumes: rba_pkg and rba_bank compiled first; apb slave answers with pready.
 */
`timescale 1ns/1ps
`default_nettype none

module rba_bank_test;

	logic                             pclk;
	logic                             presetn;
	logic                             pwr_good_n;
	logic                             psel;
	logic                             penable;
	logic                             pwrite;
	logic [rba_pkg::RBA_AW-1:0]       paddr;
	logic [rba_pkg::RBA_DW-1:0]       pwdata;
	logic [3:0]                       pstrb;
	logic [rba_pkg::RBA_SRC_W-1:0]    req_src;
	logic [7:0]                       hw_ro_data, hw_rw_data, hw_rc_set, hw_rw1c_set;
	logic [7:0]                       hw_rw0c_set, hw_readable_set_only_bit_clr, hw_ros_data, hw_sticky_write_one_clear_bit_set;
	logic [7:0]                       fw_wr_data;
	logic                             hw_rw_we, hw_ros_we, hw_lock, fw_wr_valid;
	logic [rba_pkg::RBA_DW-1:0]       prdata;
	logic                             pready;
	logic                             pslverr;
	rba_pkg::rba_ctl_t                ctl;
	rba_pkg::rba_stat_t               stat;
	rba_pkg::rba_sticky_t             sticky;
	integer                           seed;
	int                               n_mismatch;
	int                               tests_run;
	logic [7:0]                       a, b, c, m;

	rba_bank rba_bank_inst (.pclk(pclk), .presetn(presetn), .pwr_good_n(pwr_good_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .req_src(req_src), .hw_ro_data(hw_ro_data), .hw_rw_we(hw_rw_we),
		.hw_rw_data(hw_rw_data), .hw_rc_set(hw_rc_set), .hw_rw1c_set(hw_rw1c_set),
		.hw_rw0c_set(hw_rw0c_set), .hw_readable_set_only_bit_clr(hw_readable_set_only_bit_clr), .hw_ros_we(hw_ros_we),
		.hw_ros_data(hw_ros_data), .hw_sticky_write_one_clear_bit_set(hw_sticky_write_one_clear_bit_set), .hw_lock(hw_lock),
		.fw_wr_valid(fw_wr_valid), .fw_wr_data(fw_wr_data), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ctl(ctl), .stat(stat), .sticky(sticky));

	////////////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	initial begin
		#200000;
		n_mismatch++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////////
	// compare, bus cycle and reset tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer: setup, then access held until pready
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [7:0] d,
		input logic [1:0] src, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'h00_0000, d}; // reserved bits written back as read
		req_src <= src;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the slave; only the watchdog ends a hang
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [7:0] d, input logic [1:0] src);
		logic [31:0] q;
		xfer(1'b1, ad, d, src, q);
	endtask

	task automatic rchk(input logic [7:0] ad, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, ad, 8'h00, 2'h0, q);
		chk(q, {24'h00_0000, e});
	endtask

	// pg high pulses the power-good reset, else the hard reset
	task automatic rst(input logic pg);
		@(posedge pclk);
		if (pg)
			pwr_good_n <= 1'b0;
		else
			presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pwr_good_n <= 1'b1;
	endtask

	task automatic report_and_stop();
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		seed = 77987;
		n_mismatch = 0;
		tests_run = 0;
		{presetn, pwr_good_n, psel, penable, pwrite, paddr, pwdata, req_src} = '0;
		{hw_rw_we, hw_rw_data, hw_rc_set, hw_rw1c_set, hw_rw0c_set, hw_readable_set_only_bit_clr} = '0;
		{hw_ros_we, hw_ros_data, hw_sticky_write_one_clear_bit_set, hw_lock, fw_wr_valid, fw_wr_data} = '0;
		pstrb = 4'hf;
		hw_ro_data = 8'($random(seed));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		pwr_good_n <= 1'b1;
		// defaults of every word, unmapped words read zero
		for (int i = 0; i < 20; i++)
			rchk(8'(i * 4), (i == 0) ? hw_ro_data : 8'h00);
		rchk(8'hfc, 8'h00);
		wr(rba_pkg::RBA_OFF_RO, ~hw_ro_data, 2'h0);
		rchk(rba_pkg::RBA_OFF_RO, hw_ro_data);
		// plain read-write, corners then random, then hardware update
		for (int i = 0; i < 6; i++) begin
			a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
			wr(rba_pkg::RBA_OFF_RW, a, 2'(i));
			rchk(rba_pkg::RBA_OFF_RW, a);
		end
		a = 8'($random(seed));
		hw_rw_data <= a;
		hw_rw_we <= 1'b1;
		@(posedge pclk);
		hw_rw_we <= 1'b0;
		rchk(rba_pkg::RBA_OFF_RW, a);
		// read-to-clear
		a = 8'($random(seed)) | 8'h01;
		hw_rc_set <= a;
		@(posedge pclk);
		hw_rc_set <= 8'h00;
		rchk(rba_pkg::RBA_OFF_RC, a);
		rchk(rba_pkg::RBA_OFF_RC, 8'h00);
		// write-one-to-set and write-only
		a = 8'($random(seed));
		b = 8'($random(seed)) | 8'h80;
		wr(rba_pkg::RBA_OFF_W1S, a, 2'h0);
		wr(rba_pkg::RBA_OFF_W1S, b, 2'h0);
		wr(rba_pkg::RBA_OFF_WO, a | 8'h01, 2'h0);
		@(negedge pclk);
		chk(32'(ctl.w1s), 32'(a | b));
		chk(32'(ctl.wo), 32'h0000_0000);
		wr(rba_pkg::RBA_OFF_WO, b, rba_pkg::RBA_SRC_UCODE);
		@(negedge pclk);
		chk(32'(ctl.wo), 32'(b));
		// clear-on-one, clear-on-zero, readable set-only
		a = 8'($random(seed));
		m = 8'($random(seed));
		hw_rw1c_set <= a;
		hw_rw0c_set <= a;
		@(posedge pclk);
		{hw_rw1c_set, hw_rw0c_set} <= '0;
		wr(rba_pkg::RBA_OFF_RW1C, m, 2'h0);
		wr(rba_pkg::RBA_OFF_RW0C, m, 2'h0);
		rchk(rba_pkg::RBA_OFF_RW1C, a & ~m);
		rchk(rba_pkg::RBA_OFF_RW0C, a & m);
		wr(rba_pkg::RBA_OFF_READABLE_SET_ONLY_BIT, a, 2'h0);
		wr(rba_pkg::RBA_OFF_READABLE_SET_ONLY_BIT, 8'h00, 2'h0);
		rchk(rba_pkg::RBA_OFF_READABLE_SET_ONLY_BIT, a);
		hw_readable_set_only_bit_clr <= m;
		@(posedge pclk);
		hw_readable_set_only_bit_clr <= 8'h00;
		rchk(rba_pkg::RBA_OFF_READABLE_SET_ONLY_BIT, a & ~m);
		// forced write: bus refused, side path accepted
		wr(rba_pkg::RBA_OFF_FW, a | 8'h01, 2'h0);
		rchk(rba_pkg::RBA_OFF_FW, 8'h00);
		fw_wr_data <= b;
		fw_wr_valid <= 1'b1;
		@(posedge pclk);
		fw_wr_valid <= 1'b0;
		rchk(rba_pkg::RBA_OFF_FW, b);
		// write-once, sticky cells, hard reset then power-good reset
		a = 8'($random(seed)) | 8'h01;
		b = ~a;
		c = 8'($random(seed)) | 8'h01;
		wr(rba_pkg::RBA_OFF_RWO, a, 2'h0);
		wr(rba_pkg::RBA_OFF_RWO, b, 2'h0);
		rchk(rba_pkg::RBA_OFF_RWO, a);
		wr(rba_pkg::RBA_OFF_RWS, a, 2'h0);
		wr(rba_pkg::RBA_OFF_SLB, c, 2'h0);
		hw_ros_data <= c;
		hw_ros_we <= 1'b1;
		hw_sticky_write_one_clear_bit_set <= 8'hff;
		@(posedge pclk);
		{hw_ros_we, hw_sticky_write_one_clear_bit_set} <= '0;
		wr(rba_pkg::RBA_OFF_ROS, b, 2'h0);
		wr(rba_pkg::RBA_OFF_STICKY_WRITE_ONE_CLEAR_BIT, a, 2'h0);
		rst(1'b0);
		rchk(rba_pkg::RBA_OFF_ROS, c);
		rchk(rba_pkg::RBA_OFF_RWS, a);
		rchk(rba_pkg::RBA_OFF_STICKY_WRITE_ONE_CLEAR_BIT, ~a);
		rchk(rba_pkg::RBA_OFF_SLB, c);
		rchk(rba_pkg::RBA_OFF_RW, 8'h00);
		wr(rba_pkg::RBA_OFF_RWO, b, 2'h0);
		rchk(rba_pkg::RBA_OFF_RWO, b);
		rst(1'b1);
		@(negedge pclk);
		chk(32'(sticky), 32'h0000_0000);
		// lock, lock agent and lock bypass by source
		wr(rba_pkg::RBA_OFF_RWL, a, 2'h0);
		wr(rba_pkg::RBA_OFF_KL, 8'h01, 2'h0);
		wr(rba_pkg::RBA_OFF_RWL, b, 2'h0);
		rchk(rba_pkg::RBA_OFF_RWL, a);
		wr(rba_pkg::RBA_OFF_KL, 8'h00, 2'h0);
		wr(rba_pkg::RBA_OFF_RWL, b, 2'h0);
		rchk(rba_pkg::RBA_OFF_RWL, b);
		hw_lock <= 1'b1;
		wr(rba_pkg::RBA_OFF_KL, 8'h01, 2'h0);
		wr(rba_pkg::RBA_OFF_RWL, a, 2'h0);
		rchk(rba_pkg::RBA_OFF_KL, 8'h00);
		rchk(rba_pkg::RBA_OFF_RWL, b);
		wr(rba_pkg::RBA_OFF_LBEN, 8'h02, 2'h0);
		wr(rba_pkg::RBA_OFF_LBEN, 8'hff, 2'h0);
		rchk(rba_pkg::RBA_OFF_LBEN, 8'h02);
		wr(rba_pkg::RBA_OFF_LB, a, rba_pkg::RBA_SRC_LCORE);
		rchk(rba_pkg::RBA_OFF_LB, 8'h00);
		wr(rba_pkg::RBA_OFF_LB, a, rba_pkg::RBA_SRC_RCORE);
		rchk(rba_pkg::RBA_OFF_LB, a);
		wr(rba_pkg::RBA_OFF_SLB, c, rba_pkg::RBA_SRC_RCORE);
		wr(rba_pkg::RBA_OFF_SLB, 8'h00, rba_pkg::RBA_SRC_AGENT);
		rchk(rba_pkg::RBA_OFF_SLB, c);
		hw_lock <= 1'b0;
		rst(1'b0);
		rchk(rba_pkg::RBA_OFF_SLB, c);
		rchk(rba_pkg::RBA_OFF_LBEN, 8'h00);
		rchk(rba_pkg::RBA_OFF_LB, 8'h00);
		// software re-arms the non-sticky lock after the reset
		wr(rba_pkg::RBA_OFF_KL, 8'h01, 2'h0);
		wr(rba_pkg::RBA_OFF_RWL, a, 2'h0);
		rchk(rba_pkg::RBA_OFF_RWL, 8'h00);
		report_and_stop();
	end

endmodule // rba_bank_test

`default_nettype wire
